// >>> logic/pipe_ctrl_pkg.sv
// constants for the per-pipe control and status register
package pipe_ctrl_pkg;
    localparam int DATA_W = 16;
    // field positions
    localparam int BIT_ACCESS_OK = 15;
    localparam int BIT_TX_PENDING = 14;
    localparam int BIT_CSPLIT_CLEAR = 13;
    localparam int BIT_CSPLIT_STS = 12;
    localparam int BIT_AUTO_REPLY = 10;
    localparam int BIT_AUTO_CLEAR = 9;
    localparam int BIT_TOGGLE_ZERO = 8;
    localparam int BIT_TOGGLE_ONE = 7;
    localparam int BIT_TOGGLE_EXP = 6;
    localparam int BIT_PIPE_IN_USE = 5;
    localparam int BIT_RESP_LO = 0;
    // response encodings
    localparam logic [1:0] RESP_NAK = 2'h0;
    localparam logic [1:0] RESP_BUF = 2'h1;
    localparam logic [1:0] RESP_STALL = 2'h2;
    localparam logic [1:0] RESP_STALL_ALT = 2'h3;
    // reset values
    localparam logic [1:0] RESP_RESET = 2'h0;
    localparam logic RST_FLAG = 1'b0;
    // handshake chosen for the next token
    typedef enum logic [3:0] {
        HS_NAK = 4'h1,
        HS_DATA = 4'h2,
        HS_STALL = 4'h4,
        HS_ZLP = 4'h8
    } handshake_e;
endpackage

// >>> logic/usb_pipe_control_register.sv
// per-pipe control and status register with buffer access and toggle tracking
// Summary of operation
// - bit 15 is read-only hardware flag showing cpu may access pipe buffer.
// - receive, release off: flag rises when data readable, falls when fully read.
// - receive, release on, auto-clear off: flag holds until buffer-clear command.
// - transmit, release and auto-clear off: flag rises when writable, falls when written.
// - transmit: bit 14 set when a side is written, cleared when all sent.
// - double buffer: pending reads zero once both sides sent and none refilled.
// - receive: bit 14 mirrors the buffer access flag.
// - host: writing one to bit 13 clears split status; bit reads zero.
// - split clear with status already zero leaves status zero.
// - host: bit 12 sets at complete-split start, clears at its end.
// - split status reads zero in peripheral mode.
// - bit 9 is a software bit enabling auto clear, initialising all buffers.
// - writing one to bit 8 sets expected toggle to DATA0; reads zero.
// - writing one to bit 7 sets expected toggle to DATA1; reads zero.
// - bit 6 shows expected toggle, 0 DATA0, 1 DATA1.
// - bit 5 reads one while pipe is in a bus transaction.
// - bits 1-0 pick handshake: 00 NAK, 01 buffer, 10/11 STALL.
// - usb bus reset in peripheral mode forces response to NAK.
`timescale 1ns/10ps
module usb_pipe_control_register (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // cpu register port
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // pipe configuration
    input wire logic host_mode_i,
    input wire logic dir_tx_i,
    input wire logic per_transfer_release_i,
    input wire logic read_auto_clear_i,
    input wire logic double_buffer_sel_i,
    // fifo side events
    input wire logic buffer_clear_cmd_i,
    input wire logic rx_side_ready_i,
    input wire logic rx_side_read_done_i,
    input wire logic tx_side_free_i,
    input wire logic tx_side_written_i,
    input wire logic tx_side_sent_i,
    // transaction engine
    input wire logic trans_start_i,
    input wire logic trans_end_i,
    input wire logic trans_ok_i,
    input wire logic toggle_mismatch_i,
    input wire logic csplit_start_i,
    input wire logic csplit_end_i,
    input wire logic usb_bus_reset_i,
    input wire logic hw_resp_wr_i,
    input wire logic [1:0] hw_resp_i,
    input wire logic token_in_i,
    input wire logic token_out_i,
    // controls to the engine
    output logic [1:0] response_select_o,
    output logic toggle_expected_o,
    output logic buffer_auto_clear_o,
    output logic buffers_init_o,
    output logic auto_reply_enable_o,
    output logic [3:0] handshake_o,
    output logic not_ready_event_o
);
    logic buffer_access_ok;
    logic [1:0] tx_sides_filled;
    logic csplit_in_progress;
    logic auto_reply_enable;
    logic buffer_auto_clear;
    logic toggle_expected;
    logic pipe_in_use;
    logic [1:0] response_select;
    logic [15:0] reg_rdata;
    logic buffers_init;
    logic [3:0] handshake;
    logic not_ready_event;

    logic [1:0] next_sides;
    logic next_access;
    logic [1:0] next_resp;
    logic next_toggle;
    logic [15:0] rd_word;
    logic [3:0] next_handshake;

    wire wr_csplit_clr = reg_wr_i & reg_wdata_i[pipe_ctrl_pkg::BIT_CSPLIT_CLEAR];
    wire wr_tog_zero = reg_wr_i & reg_wdata_i[pipe_ctrl_pkg::BIT_TOGGLE_ZERO];
    wire wr_tog_one = reg_wr_i & reg_wdata_i[pipe_ctrl_pkg::BIT_TOGGLE_ONE];
    wire [1:0] wr_resp = reg_wdata_i[pipe_ctrl_pkg::BIT_RESP_LO +: 2];
    wire auto_clr_rise = reg_wr_i & reg_wdata_i[pipe_ctrl_pkg::BIT_AUTO_CLEAR]
        & ~buffer_auto_clear;
    wire sides_any = |tx_sides_filled;
    // rx releases on read done unless release is on with auto-clear off
    wire rx_hold = per_transfer_release_i & ~read_auto_clear_i;
    wire auto_reply_eff = auto_reply_enable & ~host_mode_i;
    wire stall_sel = response_select[1];

    // receive access tracks data; transmit access tracks free space
    always_comb begin
        next_access = buffer_access_ok;
        if (dir_tx_i) begin
            if (tx_side_free_i)
                next_access = 1'b1;
            else if (tx_side_written_i)
                next_access = 1'b0;
        end else begin
            if (rx_side_ready_i)
                next_access = 1'b1;
            else if (rx_hold ? buffer_clear_cmd_i : rx_side_read_done_i)
                next_access = 1'b0;
        end
        if (buffers_init)
            next_access = dir_tx_i;
    end

    // count of written sides; both sent with no refill gives zero
    always_comb begin
        next_sides = tx_sides_filled;
        if (tx_side_written_i && !tx_side_sent_i && tx_sides_filled != 2'h2)
            next_sides = tx_sides_filled + 2'h1;
        else if (tx_side_sent_i && !tx_side_written_i && sides_any)
            next_sides = tx_sides_filled - 2'h1;
        if (!double_buffer_sel_i && next_sides == 2'h2)
            next_sides = 2'h1;
        if (buffers_init || !dir_tx_i)
            next_sides = 2'h0;
    end

    // hardware writes win over software; a peripheral-mode bus reset wins over both
    always_comb begin
        next_resp = response_select;
        if (reg_wr_i)
            next_resp = wr_resp;
        if (hw_resp_wr_i)
            next_resp = hw_resp_i;
        if (usb_bus_reset_i && !host_mode_i)
            next_resp = pipe_ctrl_pkg::RESP_NAK;
    end

    always_comb begin
        next_toggle = toggle_expected;
        if (trans_ok_i && !toggle_mismatch_i)
            next_toggle = ~toggle_expected;
        if (wr_tog_zero)
            next_toggle = 1'b0;
        else if (wr_tog_one)
            next_toggle = 1'b1;
    end

    // handshake for next token; stall overrides auto reply
    always_comb begin
        next_handshake = pipe_ctrl_pkg::HS_NAK;
        if (stall_sel)
            next_handshake = pipe_ctrl_pkg::HS_STALL;
        else if (response_select == pipe_ctrl_pkg::RESP_BUF) begin
            if (auto_reply_eff)
                next_handshake = dir_tx_i ? pipe_ctrl_pkg::HS_ZLP
                    : pipe_ctrl_pkg::HS_NAK;
            else
                next_handshake = pipe_ctrl_pkg::HS_DATA;
        end
    end

    always_comb begin
        rd_word = 16'h0000;
        rd_word[pipe_ctrl_pkg::BIT_ACCESS_OK] = buffer_access_ok;
        rd_word[pipe_ctrl_pkg::BIT_TX_PENDING] = dir_tx_i ? sides_any
            : buffer_access_ok;
        rd_word[pipe_ctrl_pkg::BIT_CSPLIT_STS] = csplit_in_progress & host_mode_i;
        rd_word[pipe_ctrl_pkg::BIT_AUTO_REPLY] = auto_reply_eff;
        rd_word[pipe_ctrl_pkg::BIT_AUTO_CLEAR] = buffer_auto_clear;
        rd_word[pipe_ctrl_pkg::BIT_TOGGLE_EXP] = toggle_expected;
        rd_word[pipe_ctrl_pkg::BIT_PIPE_IN_USE] = pipe_in_use;
        rd_word[pipe_ctrl_pkg::BIT_RESP_LO +: 2] = response_select;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buffer_access_ok <= pipe_ctrl_pkg::RST_FLAG;
            tx_sides_filled <= 2'h0;
            response_select <= pipe_ctrl_pkg::RESP_RESET;
            toggle_expected <= pipe_ctrl_pkg::RST_FLAG;
            buffers_init <= pipe_ctrl_pkg::RST_FLAG;
        end else begin
            buffer_access_ok <= next_access;
            tx_sides_filled <= next_sides;
            response_select <= next_resp;
            toggle_expected <= next_toggle;
            buffers_init <= auto_clr_rise;
        end
    end

    // split status: a start in the same cycle as a clear wins
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            csplit_in_progress <= pipe_ctrl_pkg::RST_FLAG;
        else if (host_mode_i && csplit_start_i)
            csplit_in_progress <= 1'b1;
        else if (csplit_end_i || (host_mode_i && wr_csplit_clr))
            csplit_in_progress <= 1'b0;
        else if (!host_mode_i)
            csplit_in_progress <= 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            auto_reply_enable <= pipe_ctrl_pkg::RST_FLAG;
            buffer_auto_clear <= pipe_ctrl_pkg::RST_FLAG;
        end else if (reg_wr_i) begin
            auto_reply_enable <= reg_wdata_i[pipe_ctrl_pkg::BIT_AUTO_REPLY];
            buffer_auto_clear <= reg_wdata_i[pipe_ctrl_pkg::BIT_AUTO_CLEAR];
        end
    end

    // busy from start to end; a new start wins over a stale end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            pipe_in_use <= pipe_ctrl_pkg::RST_FLAG;
        else if (trans_start_i)
            pipe_in_use <= 1'b1;
        else if (trans_end_i)
            pipe_in_use <= 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata <= 16'h0000;
            handshake <= pipe_ctrl_pkg::HS_NAK;
            not_ready_event <= 1'b0;
        end else begin
            reg_rdata <= rd_word;
            handshake <= next_handshake;
            not_ready_event <= auto_reply_eff && !dir_tx_i && token_out_i
                && response_select == pipe_ctrl_pkg::RESP_BUF;
        end
    end

    // token_in_i only matters to the engine; zlp choice is in handshake
    wire unused_in = token_in_i;

    assign reg_rdata_o = reg_rdata;
    assign response_select_o = response_select;
    assign toggle_expected_o = toggle_expected;
    assign buffer_auto_clear_o = buffer_auto_clear;
    assign buffers_init_o = buffers_init;
    assign auto_reply_enable_o = auto_reply_enable;
    assign handshake_o = handshake;
    assign not_ready_event_o = not_ready_event;
endmodule

// >>> testbench/cpu_reg_writer.sv
// cpu software model writing the pipe control register
`timescale 1ns/10ps
module cpu_reg_writer (
    // clock and mode
    input wire logic sys_clk_i,
    input wire logic host_mode_i,
    // register write port
    output logic reg_wr_o,
    output logic [15:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end
    // called at a falling edge; unassigned bits always written as zero
    task put(input logic [15:0] v);
        reg_wr_o = 1'b1;
        reg_wdata_o = v & (host_mode_i ? 16'h2783 : 16'h0783);
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        // stale data would hide a strobe-less capture
        reg_wdata_o = ~reg_wdata_o;
    endtask
endmodule

// >>> testbench/usb_pipe_control_register_asserts.sv
// concurrent checks on the pipe control register ports
`timescale 1ns/10ps
module usb_pipe_control_register_asserts (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // observed ports
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic host_mode_i,
    input wire logic trans_start_i,
    input wire logic trans_end_i,
    input wire logic csplit_start_i,
    input wire logic csplit_end_i,
    input wire logic usb_bus_reset_i,
    input wire logic hw_resp_wr_i,
    input wire logic [1:0] response_select_o,
    input wire logic buffer_auto_clear_o,
    input wire logic buffers_init_o,
    input wire logic [3:0] handshake_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_resp_sw_write: assert property (reg_wr_i && !hw_resp_wr_i && !usb_bus_reset_i
        |=> response_select_o == $past(reg_wdata_i[1:0])) else $error("response not written");
    a_bus_reset_nak: assert property (usb_bus_reset_i && !host_mode_i
        |=> response_select_o == 2'h0) else $error("bus reset left response");
    a_handshake_follows: assert property (response_select_o != 2'h1
        |=> handshake_o == ($past(response_select_o) == 2'h0 ? 4'h1 : 4'h4))
        else $error("handshake wrong");
    a_fixed_bits_zero: assert property (reg_rdata_o[11] == 1'b0 && reg_rdata_o[4:2] == 3'h0
        && reg_rdata_o[8:7] == 2'h0 && !reg_rdata_o[13]) else $error("fixed bit nonzero");
    a_csplit_peri_zero: assert property (!host_mode_i && !$past(host_mode_i)
        |-> !reg_rdata_o[12]) else $error("split status in peripheral");
    a_csplit_sets: assert property (host_mode_i && csplit_start_i
        ##1 (host_mode_i && !csplit_end_i && !(reg_wr_i && reg_wdata_i[13]))
        |=> reg_rdata_o[12]) else $error("split status not set");
    a_init_on_clear: assert property (reg_wr_i && reg_wdata_i[9] && !buffer_auto_clear_o
        |=> buffers_init_o && buffer_auto_clear_o) else $error("no buffer init");
    a_busy_shown: assert property (trans_start_i ##1 !trans_end_i
        |=> reg_rdata_o[5]) else $error("busy not shown");
    c_csplit: cover property (host_mode_i && csplit_start_i);
    c_init: cover property (buffers_init_o);
    c_bus_reset: cover property (usb_bus_reset_i && !host_mode_i);
endmodule
bind usb_pipe_control_register usb_pipe_control_register_asserts chk (.sys_clk_i, .rst_b_i,
    .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .host_mode_i, .trans_start_i, .trans_end_i,
    .csplit_start_i, .csplit_end_i, .usb_bus_reset_i, .hw_resp_wr_i, .response_select_o,
    .buffer_auto_clear_o, .buffers_init_o, .handshake_o);

// >>> testbench/usb_pipe_control_register_tb_top.sv
// self-checking bench for the pipe control register
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module usb_pipe_control_register_tb_top;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, host_mode_i = 1'b0, dir_tx_i = 1'b0;
    logic per_transfer_release_i = 1'b0, read_auto_clear_i = 1'b0, double_buffer_sel_i = 1'b0;
    logic buffer_clear_cmd_i = 1'b0, rx_side_ready_i = 1'b0, rx_side_read_done_i = 1'b0;
    logic tx_side_free_i = 1'b0, tx_side_written_i = 1'b0, tx_side_sent_i = 1'b0;
    logic trans_start_i = 1'b0, trans_end_i = 1'b0, trans_ok_i = 1'b0, toggle_mismatch_i = 1'b0;
    logic csplit_start_i = 1'b0, csplit_end_i = 1'b0, usb_bus_reset_i = 1'b0;
    logic hw_resp_wr_i = 1'b0, token_in_i = 1'b0, token_out_i = 1'b0;
    logic [1:0] hw_resp_i = 2'h0, response_select_o;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic reg_wr_i, toggle_expected_o, buffer_auto_clear_o, buffers_init_o;
    logic auto_reply_enable_o, not_ready_event_o;
    logic [3:0] handshake_o;
    int num_errors = 0;
    int compares = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    cpu_reg_writer cpu (.sys_clk_i, .host_mode_i, .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
    usb_pipe_control_register dut (.sys_clk_i, .rst_b_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
        .host_mode_i, .dir_tx_i, .per_transfer_release_i, .read_auto_clear_i,
        .double_buffer_sel_i, .buffer_clear_cmd_i, .rx_side_ready_i, .rx_side_read_done_i,
        .tx_side_free_i, .tx_side_written_i, .tx_side_sent_i, .trans_start_i, .trans_end_i,
        .trans_ok_i, .toggle_mismatch_i, .csplit_start_i, .csplit_end_i, .usb_bus_reset_i,
        .hw_resp_wr_i, .hw_resp_i, .token_in_i, .token_out_i, .response_select_o,
        .toggle_expected_o, .buffer_auto_clear_o, .buffers_init_o, .auto_reply_enable_o,
        .handshake_o, .not_ready_event_o);
    task step(int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // spare cycle after the pulse keeps back-to-back calls legal and rdata settled
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask
    task t_resp();
        `CHK(reg_rdata_o, 16'h0000)
        for (int i = 0; i < 4; i++) begin
            cpu.put(16'(i));
            `CHK(response_select_o, 2'(i))
            step(1);
            `CHK(handshake_o, i == 0 ? 4'h1 : (i == 1 ? 4'h2 : 4'h4))
        end
        hw_resp_wr_i = 1'b1;
        hw_resp_i = 2'h3;
        cpu.put(16'h0001);
        hw_resp_wr_i = 1'b0;
        `CHK(response_select_o, 2'h3)
        pulse(usb_bus_reset_i);
        `CHK(response_select_o, 2'h0)
        $display("response test done");
    endtask
    task t_toggle();
        cpu.put(16'h0080);
        step(1);
        `CHK(reg_rdata_o[7:6], 2'h1)
        pulse(trans_ok_i);
        `CHK(toggle_expected_o, 1'b0)
        toggle_mismatch_i = 1'b1;
        pulse(trans_ok_i);
        toggle_mismatch_i = 1'b0;
        `CHK(toggle_expected_o, 1'b0)
        pulse(trans_ok_i);
        cpu.put(16'h0100);
        step(1);
        `CHK(reg_rdata_o[8:6], 3'h0)
        pulse(trans_start_i);
        `CHK(reg_rdata_o[5], 1'b1)
        pulse(trans_end_i);
        `CHK(reg_rdata_o[5], 1'b0)
        $display("toggle test done");
    endtask
    task t_csplit();
        host_mode_i = 1'b1;
        pulse(csplit_start_i);
        `CHK(reg_rdata_o[13:12], 2'h1)
        cpu.put(16'h2000);
        step(1);
        `CHK(reg_rdata_o[13:12], 2'h0)
        cpu.put(16'h2000);
        step(1);
        `CHK(reg_rdata_o[12], 1'b0)
        pulse(csplit_start_i);
        pulse(csplit_end_i);
        `CHK(reg_rdata_o[12], 1'b0)
        host_mode_i = 1'b0;
        pulse(csplit_start_i);
        `CHK(reg_rdata_o[12], 1'b0)
        $display("split test done");
    endtask
    task t_buffers();
        pulse(rx_side_ready_i);
        `CHK(reg_rdata_o[15:14], 2'h3)
        pulse(rx_side_read_done_i);
        `CHK(reg_rdata_o[15:14], 2'h0)
        per_transfer_release_i = 1'b1;
        pulse(rx_side_ready_i);
        pulse(rx_side_read_done_i);
        `CHK(reg_rdata_o[15], 1'b1)
        pulse(buffer_clear_cmd_i);
        `CHK(reg_rdata_o[15], 1'b0)
        // release on with auto-clear on drops the flag at read done again
        read_auto_clear_i = 1'b1;
        pulse(rx_side_ready_i);
        `CHK(reg_rdata_o[15], 1'b1)
        pulse(rx_side_read_done_i);
        `CHK(reg_rdata_o[15], 1'b0)
        read_auto_clear_i = 1'b0;
        per_transfer_release_i = 1'b0;
        dir_tx_i = 1'b1;
        pulse(tx_side_free_i);
        `CHK(reg_rdata_o[15:14], 2'h2)
        pulse(tx_side_written_i);
        `CHK(reg_rdata_o[15:14], 2'h1)
        pulse(tx_side_sent_i);
        `CHK(reg_rdata_o[14], 1'b0)
        double_buffer_sel_i = 1'b1;
        pulse(tx_side_written_i);
        pulse(tx_side_written_i);
        pulse(tx_side_sent_i);
        `CHK(reg_rdata_o[14], 1'b1)
        pulse(tx_side_sent_i);
        `CHK(reg_rdata_o[14], 1'b0)
        dir_tx_i = 1'b0;
        double_buffer_sel_i = 1'b0;
        $display("buffer test done");
    endtask
    task t_auto();
        cpu.put(16'h0601);
        `CHK({buffers_init_o, buffer_auto_clear_o, auto_reply_enable_o}, 3'h7)
        pulse(token_out_i);
        step(1);
        `CHK(reg_rdata_o[10:9], 2'h3)
        token_out_i = 1'b1;
        step(1);
        token_out_i = 1'b0;
        `CHK(not_ready_event_o, 1'b1)
        dir_tx_i = 1'b1;
        pulse(token_in_i);
        `CHK(handshake_o, 4'h8)
        dir_tx_i = 1'b0;
        $display("auto test done");
    endtask
    task give_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        step(20);
        rst_b_i = 1'b1;
        step(1);
        t_resp();
        t_toggle();
        t_csplit();
        t_buffers();
        t_auto();
        give_verdict();
    end
    // cut a hang short
    initial begin
        #3000000;
        num_errors++;
        give_verdict();
    end
endmodule
